// >>> bench/opsp_host.sv
// Host model for the programming pin: open-drain sender and receiver
`timescale 1ns/100ps
`default_nettype none
module opsp_host (
  input  wire logic i_clk,
  input  wire logic i_line,
  output var logic  o_pull
);
  initial o_pull = 1'b0;
  // Whole cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic pull(input logic v);
    o_pull <= v;
  endtask : pull
  // Start bit, data LSB first, 1.5 bit stop, half bit idle
  task automatic send_byte(input logic [7:0] b, input int bp, input logic bad_stop);
    o_pull <= 1'b1;
    tick(bp);
    for (int i = 0; i < 8; i++) begin
      o_pull <= ~b[i];
      tick(bp);
    end
    o_pull <= bad_stop;
    tick(bp + bp / 2);
    o_pull <= 1'b0;
    tick(bp / 2);
  endtask : send_byte
  // Line held low, then released to the pull-up
  task automatic send_break(input int n);
    o_pull <= 1'b1;
    tick(n);
    o_pull <= 1'b0;
    tick(1);
  endtask : send_break
  // Centre-sampled receive; ok low when no start bit came
  task automatic recv(input int bp, output logic [7:0] b, output logic ok);
    int n;
    b = 8'h00;
    for (n = 0; n < 4000 && i_line !== 1'b0; n++) tick(1);
    ok = (n < 4000);
    tick(bp + bp / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = i_line;
      tick(bp);
    end
  endtask : recv
endmodule : opsp_host
`default_nettype wire

// >>> bench/opsp_port_bench.sv
// Self-checking bench for the one-pin programming port
`timescale 1ns/100ps
`default_nettype none
module opsp_port_bench;
  import opsp_pkg::*;
  localparam int BP  = 16;
  localparam int BP2 = 24;
  logic          i_core_clk = 1'b0;
  logic          i_reset_n = 1'b0;
  logic          i_por_active = 1'b1;
  logic          i_user_pin_data = 1'b0;
  logic          i_wdt_enable = 1'b1;
  logic          i_tx_valid = 1'b0;
  opsp_byte_type i_tx_data = 8'h00;
  logic          o_tx_ready, o_pin_out, o_pin_oe_n, o_pullup_en, o_prog_mode;
  logic          o_cpu_halt, o_periph_disable, o_wdt_refresh, o_flash_access_enable;
  logic          o_rx_valid, o_cmd_abort, o_err_break, o_err_frame, o_err_collision;
  opsp_byte_type o_rx_data;
  opsp_byte_type rx_last = 8'h00;
  logic          host_pull;
  wire           pin_line;
  int            n_fail = 0, comparisons = 0, n_rx = 0, n_frm = 0, n_brk = 0;
  int            n_abt = 0, n_col = 0;

  always #4 i_core_clk = ~i_core_clk;
  assign pin_line = ~host_pull & (o_pin_oe_n | o_pin_out);

  opsp_port opsp_port_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_por_active(i_por_active),
    .i_pin_in(pin_line), .i_user_pin_data(i_user_pin_data), .i_wdt_enable(i_wdt_enable),
    .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
    .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_pullup_en(o_pullup_en),
    .o_prog_mode(o_prog_mode), .o_cpu_halt(o_cpu_halt), .o_periph_disable(o_periph_disable),
    .o_wdt_refresh(o_wdt_refresh), .o_flash_access_enable(o_flash_access_enable),
    .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_cmd_abort(o_cmd_abort),
    .o_err_break(o_err_break), .o_err_frame(o_err_frame), .o_err_collision(o_err_collision)
  );
  opsp_host opsp_host_i (.i_clk(i_core_clk), .i_line(pin_line), .o_pull(host_pull));

  // Pulse counters
  always @(posedge i_core_clk) begin
    if (o_rx_valid === 1'b1) begin
      n_rx++;
      rx_last = o_rx_data;
    end
    if (o_err_frame === 1'b1) n_frm++;
    if (o_err_break === 1'b1) n_brk++;
    if (o_cmd_abort === 1'b1) n_abt++;
    if (o_err_collision === 1'b1) n_col++;
  end

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc

  // Offer one byte; took high when the FIFO accepted it
  task automatic push(input opsp_byte_type d, output logic took);
    i_tx_valid <= 1'b1;
    i_tx_data  <= d;
    for (int n = 0; n < 20; n++) begin
      @(negedge i_core_clk);
      took = (o_tx_ready === 1'b1);
      @(posedge i_core_clk);
      if (took) break;
    end
  endtask : push

  task automatic wait_high(output int n);
    for (n = 0; n < 3000 && pin_line !== 1'b1; n++) @(negedge i_core_clk);
    if (n == 3000) begin
      n_fail++;
      give_verdict();
    end
  endtask : wait_high

  task automatic power_up(input logic prog);
    @(posedge i_core_clk);
    i_reset_n    <= 1'b0;
    i_por_active <= 1'b1;
    opsp_host_i.pull(prog);
    cyc(16);
    i_reset_n <= 1'b1;
    cyc(4);
    @(negedge i_core_clk);
    check("por_oe_n", o_pin_oe_n, 1'b1);
    check("por_pullup", o_pullup_en, 1'b1);
    @(posedge i_core_clk);
    i_por_active <= 1'b0;
    cyc(4);
    opsp_host_i.pull(1'b0);
    cyc(4);
    @(negedge i_core_clk);
  endtask : power_up

  task automatic test_user();
    power_up(1'b0);
    @(posedge i_core_clk);
    i_user_pin_data <= 1'b1;
    cyc(3);
    @(negedge i_core_clk);
    check("user_mode", o_prog_mode, 1'b0);
    check("user_oe_n", o_pin_oe_n, 1'b0);
    check("user_out", o_pin_out, 1'b1);
    check("user_pullup", o_pullup_en, 1'b0);
    check("user_halt", o_cpu_halt, 1'b0);
    $display("test_user done");
  endtask : test_user

  task automatic test_prog();
    power_up(1'b1);
    check("prog_mode", o_prog_mode, 1'b1);
    check("prog_halt", o_cpu_halt, 1'b1);
    check("prog_periph", o_periph_disable, 1'b1);
    check("prog_wdt", o_wdt_refresh, 1'b1);
    check("prog_oe_n", o_pin_oe_n, 1'b1);
    check("prog_pullup", o_pullup_en, 1'b1);
    check("prog_flash", o_flash_access_enable, 1'b0);
    @(posedge i_core_clk);
    i_wdt_enable <= 1'b0;
    cyc(3);
    @(negedge i_core_clk);
    check("wdt_off", o_wdt_refresh, 1'b0);
    @(posedge i_core_clk);
    i_wdt_enable <= 1'b1;
    $display("test_prog done");
  endtask : test_prog

  task automatic test_fifo_tx();
    logic       took;
    logic       ok;
    logic [7:0] b;
    int         r0;
    r0 = n_rx;
    for (int i = 0; i < 9; i++) begin
      push(8'hC3 + 8'(i), took);
      check("fifo_take", took, 16'(i < 8));
    end
    i_tx_valid <= 1'b0;
    cyc(4);
    opsp_host_i.send_byte(8'h80, BP, 1'b0);
    check("cal_no_rx", n_rx, r0);
    for (int i = 0; i < 8; i++) begin
      opsp_host_i.recv(BP, b, ok);
      check("tx_start", ok, 1'b1);
      check("tx_byte", b, 8'hC3 + 8'(i));
    end
    $display("test_fifo_tx done");
  endtask : test_fifo_tx

  task automatic test_rx_busy();
    logic       took;
    logic       ok;
    logic [7:0] b;
    int         c0;
    opsp_host_i.tick(3 * BP);
    c0 = n_col;
    fork
      opsp_host_i.send_byte(8'hA5, BP, 1'b0);
      begin
        cyc(2 * BP);
        push(8'h96, took);
        i_tx_valid <= 1'b0;
        cyc(8 * BP);
        opsp_host_i.recv(BP, b, ok);
      end
    join
    check("rx_byte", rx_last, 8'hA5);
    check("tx_after_rx", b, 8'h96);
    check("no_collision", n_col, c0);
    opsp_host_i.tick(3 * BP);
    $display("test_rx_busy done");
  endtask : test_rx_busy

  task automatic test_ctl();
    check("flash_before", o_flash_access_enable, 1'b0);
    opsp_host_i.send_byte(8'h04, BP, 1'b0);
    opsp_host_i.send_byte(8'h01, BP, 1'b0);
    cyc(4);
    @(negedge i_core_clk);
    check("flash_after", o_flash_access_enable, 1'b1);
    check("ctl_data", rx_last, 8'h01);
    $display("test_ctl done");
  endtask : test_ctl

  task automatic test_frame();
    int c0;
    int c1;
    int n;
    c0 = n_frm;
    c1 = n_abt;
    opsp_host_i.send_byte(8'h55, BP, 1'b1);
    cyc(20 * BP);
    @(negedge i_core_clk);
    check("frame_err", n_frm, c0 + 1);
    check("frame_abort", n_abt, c1 + 1);
    check("err_break_low", pin_line, 1'b0);
    wait_high(n);
    check("err_break_len", 16'(n > 290 && n < 370), 1'b1);
    check("ctl_kept", o_flash_access_enable, 1'b1);
    cyc(BP2);
    opsp_host_i.send_byte(8'h80, BP2, 1'b0);
    opsp_host_i.send_byte(8'h5A, BP2, 1'b0);
    check("recal_byte", rx_last, 8'h5A);
    $display("test_frame done");
  endtask : test_frame

  task automatic test_break();
    int c0;
    int n;
    c0 = n_brk;
    opsp_host_i.tick(3 * BP2);
    opsp_host_i.send_break(12 * BP2);
    check("host_break", n_brk, c0 + 1);
    wait_high(n);
    check("break_ctl_kept", o_flash_access_enable, 1'b1);
    cyc(BP);
    opsp_host_i.send_byte(8'h80, BP, 1'b0);
    opsp_host_i.send_byte(8'h3C, BP, 1'b0);
    check("break_recal", rx_last, 8'h3C);
    $display("test_break done");
  endtask : test_break

  task automatic test_collide();
    logic took;
    int   c0;
    int   c1;
    int   n;
    c0 = n_col;
    c1 = n_abt;
    push(8'hFF, took);
    i_tx_valid <= 1'b0;
    check("col_take", took, 1'b1);
    for (n = 0; n < 200 && pin_line !== 1'b0; n++) @(posedge i_core_clk);
    check("col_start", 16'(n < 200), 1'b1);
    cyc(BP + BP / 2);
    opsp_host_i.pull(1'b1);
    cyc(BP);
    opsp_host_i.pull(1'b0);
    cyc(4);
    @(negedge i_core_clk);
    check("collision", n_col, c0 + 1);
    check("col_abort", n_abt, c1 + 1);
    check("col_break_low", pin_line, 1'b0);
    wait_high(n);
    $display("test_collide done");
  endtask : test_collide

  initial begin
    test_user();
    test_prog();
    test_fifo_tx();
    test_rx_busy();
    test_ctl();
    test_frame();
    test_break();
    test_collide();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge i_core_clk);
    n_fail++;
    give_verdict();
  end
endmodule : opsp_port_bench
`default_nettype wire

// >>> hdl/opsp_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module opsp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  opsp_fifo_if.fifo f
);
  import opsp_pkg::*;
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_ff [D];
  logic [W-1:0]  nxt_mem [D];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          ready_ff, nxt_ready, valid_ff, nxt_valid;
  logic          do_push, do_pop;

  assign f.push_ready = ready_ff;
  assign f.pop_valid  = valid_ff;
  assign f.pop_data   = mem_ff[rd_ff];

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    do_push = f.push_valid && ready_ff;
    do_pop  = f.pop_ready && valid_ff;
    if (do_push) begin
      nxt_mem[wr_ff] = f.push_data;
      nxt_wr = (wr_ff == AW'(D - 1)) ? '0 : AW'(wr_ff + 1'b1);
    end
    if (do_pop) begin
      nxt_rd = (rd_ff == AW'(D - 1)) ? '0 : AW'(rd_ff + 1'b1);
    end
    nxt_cnt   = CW'(cnt_ff + CW'(do_push) - CW'(do_pop));
    nxt_ready = (nxt_cnt != CW'(D));
    nxt_valid = (nxt_cnt != '0);
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < D; i++) begin
        mem_ff[i] <= '0;
      end
      wr_ff    <= '0;
      rd_ff    <= '0;
      cnt_ff   <= '0;
      ready_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      mem_ff   <= nxt_mem;
      wr_ff    <= nxt_wr;
      rd_ff    <= nxt_rd;
      cnt_ff   <= nxt_cnt;
      ready_ff <= nxt_ready;
      valid_ff <= nxt_valid;
    end
  end
endmodule : opsp_fifo
`default_nettype wire

// >>> hdl/opsp_fifo_if.sv
// Valid/ready carrier between the port and its transmit FIFO
`timescale 1ns/100ps
`default_nettype none
interface opsp_fifo_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport src  (output push_valid, output push_data, input push_ready,
                input pop_valid, input pop_data, output pop_ready);
  modport fifo (input push_valid, input push_data, output push_ready,
                output pop_valid, output pop_data, input pop_ready);
endinterface : opsp_fifo_if
`default_nettype wire

// >>> hdl/opsp_map.svh
// Offsets, field positions, reset values and counts of the one-pin programming port
`ifndef OPSP_MAP_SVH
`define OPSP_MAP_SVH
`define OPSP_CMD_CTL_WR   8'h04
`define OPSP_CTL_RST      8'h00
`define OPSP_CTL_FAE_BIT  0
`define OPSP_LAST_DATA    6'h07
`define OPSP_LAST_TX_BIT  6'h09
`define OPSP_STOP_BIT     6'h08
`define OPSP_CAL_SHIFT    3
`define OPSP_CAL_MAX      16'h1FFF
`define OPSP_BIT_DFLT     10'h200
`define OPSP_BIT_MIN      10'h002
`define OPSP_BRK_BITS     6'h09
`define OPSP_ERR_BRK_BITS 6'h2A
`define OPSP_CAL_GUARD    6'h03
`define OPSP_FIFO_WIDTH   8
`define OPSP_FIFO_DEPTH   8
`endif

// >>> hdl/opsp_pkg.sv
// Types shared by the one-pin programming port
package opsp_pkg;
  typedef logic [7:0] opsp_byte_type;
  typedef enum logic [1:0] {MODE_POR, MODE_USER, MODE_PROG} opsp_mode_type;
  typedef enum logic [3:0] {
    ST_OFF, ST_UNCAL, ST_CAL, ST_HUNT, ST_RX_START, ST_RX_DATA, ST_RX_STOP,
    ST_TX, ST_BRK_TX, ST_BRK_WAIT
  } opsp_link_type;
endpackage : opsp_pkg

// >>> hdl/opsp_port.sv
// One-pin programming port: mode capture, auto-baud, receiver, transmitter, errors
//
// Contract
// - During power-on reset the pin is an input with pull-up on.
// - Pin low at the end of power-on reset enters programming mode.
// - Pin high at the end of power-on reset gives user mode, output-only pin.
// - In programming mode the pin is open-drain with pull-up, steered by tx/rx.
// - Programming mode halts the core and disables all peripherals.
// - Programming mode keeps refreshing an enabled watchdog.
// - Flash access stays blocked until the flash-access enable bit is 1.
// - The link is half-duplex, never sending and receiving together.
// - Characters are start bit, eight data bits LSB first, 1.5 stop bits.
// - After reset the port idles; the first host character is 80H.
// - Auto-baud times the eight-bit low run of 80H and sets the bit rate.
// - Auto-baud runs on the system clock, from clock/1023 up to clock/2.
// - Nine or more low bit times is a break and resets auto-baud.
// - Errors detected are break, framing (low stop) and collision.
// - Any error aborts the command, sends a four-character break, resets auto-baud.
// - Host break holds port reset until pin high; control register unchanged.
// - Transmitter waits an extra half bit after any stop bit.
// - Receiver hunts for a start bit right after a valid mid-stop sample.
// - Transmitter does not start while a character is being received.
// - Command 04H plus one data byte writes the port control register.
`timescale 1ns/100ps
`default_nettype none
`include "opsp_map.svh"
module opsp_port (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_por_active,
  input  wire logic                   i_pin_in,
  input  wire logic                   i_user_pin_data,
  input  wire logic                   i_wdt_enable,
  input  wire logic                   i_tx_valid,
  input  wire opsp_pkg::opsp_byte_type i_tx_data,
  output logic                        o_tx_ready,
  output logic                        o_pin_out,
  output logic                        o_pin_oe_n,
  output logic                        o_pullup_en,
  output logic                        o_prog_mode,
  output logic                        o_cpu_halt,
  output logic                        o_periph_disable,
  output logic                        o_wdt_refresh,
  output logic                        o_flash_access_enable,
  output logic                        o_rx_valid,
  output opsp_pkg::opsp_byte_type     o_rx_data,
  output logic                        o_cmd_abort,
  output logic                        o_err_break,
  output logic                        o_err_frame,
  output logic                        o_err_collision
);
  import opsp_pkg::*;

  function automatic logic [15:0] bit_times(input logic [5:0] n, input logic [9:0] b);
    return {10'h000, n} * {6'h00, b};
  endfunction : bit_times

  function automatic logic [15:0] half_of(input logic [9:0] b);
    return {7'h00, b[9:1]};
  endfunction : half_of

  opsp_fifo_if #(.W(`OPSP_FIFO_WIDTH)) tx_if ();

  opsp_fifo #(.W(`OPSP_FIFO_WIDTH), .D(`OPSP_FIFO_DEPTH)) u_tx_fifo (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .f          (tx_if.fifo)
  );

  logic          pin_meta_ff, pin_sync_ff, pin_prev_ff;
  opsp_mode_type mode_ff, nxt_mode;
  opsp_link_type st_ff, nxt_st;
  logic [15:0]   cnt_ff, nxt_cnt, guard_ff, nxt_guard, low_ff, nxt_low;
  logic [9:0]    bitp_ff, nxt_bitp, shift_ff, nxt_shift;
  logic [5:0]    nbit_ff, nxt_nbit;
  logic [7:0]    ctl_ff, nxt_ctl;
  logic          ctl_wait_ff, nxt_ctl_wait, drive_ff, nxt_drive;
  logic          nxt_rx_valid, nxt_abort, nxt_eb, nxt_ef, nxt_ec, pop;
  logic          fall, err;
  logic [7:0]    nxt_rx_data;

  assign tx_if.push_valid = i_tx_valid;
  assign tx_if.push_data  = i_tx_data;
  assign tx_if.pop_ready  = pop;
  assign o_tx_ready       = tx_if.push_ready;
  assign fall             = pin_prev_ff && !pin_sync_ff;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      pin_meta_ff <= i_pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  always_comb begin
    nxt_mode     = mode_ff;
    nxt_st       = st_ff;
    nxt_cnt      = (cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff;
    nxt_guard    = (guard_ff != 16'h0000) ? guard_ff - 16'h0001 : guard_ff;
    nxt_bitp     = bitp_ff;
    nxt_shift    = shift_ff;
    nxt_nbit     = nbit_ff;
    nxt_ctl      = ctl_ff;
    nxt_ctl_wait = ctl_wait_ff;
    nxt_drive    = 1'b0;
    nxt_rx_valid = 1'b0;
    nxt_rx_data  = o_rx_data;
    nxt_eb       = 1'b0;
    nxt_ef       = 1'b0;
    nxt_ec       = 1'b0;
    pop          = 1'b0;
    // Low run seen on the line while the port itself releases it
    nxt_low = (pin_sync_ff || drive_ff) ? 16'h0000 : low_ff + 16'h0001;
    if (i_por_active) begin
      nxt_mode = MODE_POR;
    end else if (mode_ff == MODE_POR) begin
      nxt_mode = pin_sync_ff ? MODE_USER : MODE_PROG;
    end
    case (st_ff)
      ST_OFF: begin
        if (mode_ff == MODE_PROG) begin
          nxt_st = ST_UNCAL;
        end
      end
      ST_UNCAL: begin
        nxt_cnt = 16'h0000;
        if (fall) begin
          nxt_cnt = 16'h0001;
          nxt_st  = ST_CAL;
        end
      end
      ST_CAL: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (pin_sync_ff) begin
          nxt_bitp = 10'(cnt_ff >> `OPSP_CAL_SHIFT);
          if (nxt_bitp < `OPSP_BIT_MIN) begin
            nxt_bitp = `OPSP_BIT_MIN;
          end
          nxt_guard = bit_times(`OPSP_CAL_GUARD, nxt_bitp);
          nxt_st    = ST_HUNT;
        end else if (cnt_ff >= `OPSP_CAL_MAX) begin
          nxt_eb = 1'b1;
        end
      end
      ST_HUNT: begin
        if (fall) begin
          nxt_st  = ST_RX_START;
          nxt_cnt = half_of(bitp_ff) - 16'h0001;
        end else if (guard_ff == 16'h0000 && tx_if.pop_valid) begin
          pop       = 1'b1;
          nxt_shift = {1'b1, tx_if.pop_data, 1'b0};
          nxt_nbit  = 6'h00;
          nxt_cnt   = {6'h00, bitp_ff} - 16'h0001;
          nxt_drive = 1'b1;
          nxt_st    = ST_TX;
        end
      end
      ST_RX_START: begin
        if (cnt_ff == 16'h0000) begin
          nxt_st   = pin_sync_ff ? ST_HUNT : ST_RX_DATA;
          nxt_cnt  = {6'h00, bitp_ff} - 16'h0001;
          nxt_nbit = 6'h00;
        end
      end
      ST_RX_DATA: begin
        if (cnt_ff == 16'h0000) begin
          nxt_shift = {2'b00, pin_sync_ff, shift_ff[7:1]};
          nxt_cnt   = {6'h00, bitp_ff} - 16'h0001;
          nxt_nbit  = nbit_ff + 6'h01;
          if (nbit_ff == `OPSP_LAST_DATA) begin
            nxt_st = ST_RX_STOP;
          end
        end
      end
      ST_RX_STOP: begin
        if (cnt_ff == 16'h0000) begin
          if (!pin_sync_ff) begin
            nxt_ef = 1'b1;
          end else begin
            nxt_rx_valid = 1'b1;
            nxt_rx_data  = shift_ff[7:0];
            nxt_guard    = {6'h00, bitp_ff} + half_of(bitp_ff);
            nxt_st       = ST_HUNT;
            if (ctl_wait_ff) begin
              nxt_ctl      = shift_ff[7:0];
              nxt_ctl_wait = 1'b0;
            end else begin
              nxt_ctl_wait = (shift_ff[7:0] == `OPSP_CMD_CTL_WR);
            end
          end
        end
      end
      ST_TX: begin
        nxt_drive = !shift_ff[0];
        if (shift_ff[0] && !pin_sync_ff && cnt_ff == half_of(bitp_ff)) begin
          nxt_ec = 1'b1;
        end else if (cnt_ff == 16'h0000) begin
          if (nbit_ff == `OPSP_LAST_TX_BIT) begin
            nxt_drive = 1'b0;
            nxt_guard = half_of(bitp_ff);
            nxt_st    = ST_HUNT;
          end else begin
            nxt_shift = {1'b1, shift_ff[9:1]};
            nxt_nbit  = nbit_ff + 6'h01;
            nxt_drive = !nxt_shift[0];
            nxt_cnt   = {6'h00, bitp_ff} - 16'h0001;
            if (nbit_ff == `OPSP_STOP_BIT) begin
              nxt_cnt = {6'h00, bitp_ff} + half_of(bitp_ff) - 16'h0001;
            end
          end
        end
      end
      ST_BRK_TX: begin
        nxt_drive = 1'b1;
        if (cnt_ff == 16'h0000) begin
          nxt_drive = 1'b0;
          nxt_st    = ST_BRK_WAIT;
        end
      end
      ST_BRK_WAIT: begin
        if (pin_sync_ff) begin
          nxt_bitp = `OPSP_BIT_DFLT;
          nxt_st   = ST_UNCAL;
        end
      end
      default: begin
        nxt_st = ST_OFF;
      end
    endcase
    if (st_ff > ST_CAL && st_ff < ST_BRK_TX && low_ff >= bit_times(`OPSP_BRK_BITS, bitp_ff)) begin
      nxt_eb = 1'b1;
    end
    err = nxt_eb || nxt_ef || nxt_ec;
    if (err) begin
      nxt_eb       = nxt_eb;
      nxt_rx_valid = 1'b0;
      nxt_ctl_wait = 1'b0;
      nxt_cnt      = bit_times(`OPSP_ERR_BRK_BITS, bitp_ff) - 16'h0001;
      nxt_drive    = 1'b1;
      nxt_st       = ST_BRK_TX;
    end
    nxt_abort = err;
    if (nxt_mode != MODE_PROG) begin
      nxt_st    = ST_OFF;
      nxt_drive = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_ff               <= MODE_POR;
      st_ff                 <= ST_OFF;
      cnt_ff                <= 16'h0000;
      guard_ff              <= 16'h0000;
      low_ff                <= 16'h0000;
      bitp_ff               <= `OPSP_BIT_DFLT;
      shift_ff              <= 10'h000;
      nbit_ff               <= 6'h00;
      ctl_ff                <= `OPSP_CTL_RST;
      ctl_wait_ff           <= 1'b0;
      drive_ff              <= 1'b0;
      o_pin_out             <= 1'b0;
      o_pin_oe_n            <= 1'b1;
      o_pullup_en           <= 1'b1;
      o_prog_mode           <= 1'b0;
      o_cpu_halt            <= 1'b0;
      o_periph_disable      <= 1'b0;
      o_wdt_refresh         <= 1'b0;
      o_flash_access_enable <= 1'b0;
      o_rx_valid            <= 1'b0;
      o_rx_data             <= 8'h00;
      o_cmd_abort           <= 1'b0;
      o_err_break           <= 1'b0;
      o_err_frame           <= 1'b0;
      o_err_collision       <= 1'b0;
    end else begin
      mode_ff               <= nxt_mode;
      st_ff                 <= nxt_st;
      cnt_ff                <= nxt_cnt;
      guard_ff              <= nxt_guard;
      low_ff                <= nxt_low;
      bitp_ff               <= nxt_bitp;
      shift_ff              <= nxt_shift;
      nbit_ff               <= nxt_nbit;
      ctl_ff                <= nxt_ctl;
      ctl_wait_ff           <= nxt_ctl_wait;
      drive_ff              <= nxt_drive;
      o_pin_out             <= (nxt_mode == MODE_USER) ? i_user_pin_data : 1'b0;
      o_pin_oe_n            <= (nxt_mode == MODE_USER) ? 1'b0 :
                               (nxt_mode == MODE_POR) ? 1'b1 : !nxt_drive;
      o_pullup_en           <= (nxt_mode != MODE_USER);
      o_prog_mode           <= (nxt_mode == MODE_PROG);
      o_cpu_halt            <= (nxt_mode == MODE_PROG);
      o_periph_disable      <= (nxt_mode == MODE_PROG);
      o_wdt_refresh         <= (nxt_mode == MODE_PROG) && i_wdt_enable;
      o_flash_access_enable <= (nxt_mode == MODE_PROG) && nxt_ctl[`OPSP_CTL_FAE_BIT];
      o_rx_valid            <= nxt_rx_valid;
      o_rx_data             <= nxt_rx_data;
      o_cmd_abort           <= nxt_abort;
      o_err_break           <= nxt_eb;
      o_err_frame           <= nxt_ef;
      o_err_collision       <= nxt_ec;
    end
  end

  sequence s_brk_entry;
    $rose(st_ff == ST_BRK_TX);
  endsequence

  sequence s_line_held_low;
    !o_pin_oe_n [*8];
  endsequence

  property p_por_input;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_ff == MODE_POR) |-> (o_pin_oe_n && o_pullup_en);
  endproperty
  a_por_input: assert property (p_por_input) else $error("pin driven during power-on");

  property p_prog_entry;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_ff == MODE_POR && !i_por_active && !pin_sync_ff) |=> (mode_ff == MODE_PROG);
  endproperty
  a_prog_entry: assert property (p_prog_entry) else $error("prog mode not entered");

  property p_user_entry;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_ff == MODE_POR && !i_por_active && pin_sync_ff) |=> !o_pin_oe_n && !o_pullup_en;
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user mode pin not output");

  property p_core_halt;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (mode_ff == MODE_PROG) |-> (o_cpu_halt && o_periph_disable);
  endproperty
  a_core_halt: assert property (p_core_halt) else $error("core not halted");

  property p_wdt_refresh;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (nxt_mode == MODE_PROG && i_wdt_enable) |=> o_wdt_refresh;
  endproperty
  a_wdt_refresh: assert property (p_wdt_refresh) else $error("watchdog not refreshed");

  property p_flash_gate;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      $rose(o_flash_access_enable) |-> $past(st_ff == ST_RX_STOP && ctl_wait_ff);
  endproperty
  a_flash_gate: assert property (p_flash_gate) else $error("flash enabled without write");

  property p_half_duplex;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (st_ff inside {ST_RX_START, ST_RX_DATA, ST_RX_STOP}) |-> o_pin_oe_n;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("driving while receiving");

  property p_err_break;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      s_brk_entry |-> s_line_held_low;
  endproperty
  a_err_break: assert property (p_err_break) else $error("error break too short");

  property p_tx_start;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      $rose(st_ff == ST_TX) |-> $past(st_ff == ST_HUNT && guard_ff == 16'h0000 && !fall);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx started early");
endmodule : opsp_port
`default_nettype wire
